// File: hdl/nibble_alu.sv
// four-bit arithmetic and logic unit of the execute subset, purely combinational
// assumes the caller selects operands and carry in; carry passes through unless changed
`timescale 1ns/1ns
`default_nettype none
`include "nibble_exec_map.svh"

module nibble_alu (
    input wire nibble_exec_pkg::alu_op_t op,
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic cin,
    output logic [3:0] y,
    output logic cout
);

    logic [4:0] sum;

    always_comb
    begin
        sum = 5'h00;
        y = a;
        cout = cin;
        unique case (op)
            nibble_exec_pkg::ALU_ADD:
            begin
                sum = {1'b0, a} + {1'b0, b};
                y = sum[3:0];
                cout = sum[4];
            end
            nibble_exec_pkg::ALU_ADC:
            begin
                sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
                y = sum[3:0];
                cout = sum[4];
            end
            nibble_exec_pkg::ALU_AND:
            begin
                y = a & b;
            end
            nibble_exec_pkg::ALU_DEC:
            begin
                // carry deliberately left alone
                y = a - `NIBBLE_ONE;
            end
            nibble_exec_pkg::ALU_DADJ:
            begin
                if (a > `DEC_ADJ_LIMIT || cin)
                begin
                    y = a + `DEC_ADJ_ADD;
                    cout = 1'b1;
                end
            end
            nibble_exec_pkg::ALU_PASS:
            begin
                y = a;
            end
            default:
            begin
                y = a;
            end
        endcase
    end

endmodule
`default_nettype wire

// File: hdl/nibble_cpu_exec_subset.sv
// execute subset of a 4-bit core: table reads, sound commands, power-down, alu group, call
// assumes a synchronous program rom on ref_clk with one cycle of read latency
// What this block does
// RULE_01 - table read to high register and accumulator
// RULE_02 - table read into pointed memory and accumulator
// RULE_03 - fixed page variants read from page F
// RULE_04 - two-byte sound command selects immediate channel
// RULE_05 - one-byte sound command channel from accumulator
// RULE_06 - sound one pass, loop, or stop
// RULE_07 - two-byte power-down enters halt state
// RULE_08 - add memory plus carry, carry updated
// RULE_09 - add immediate nibble, carry updated
// RULE_10 - add memory without carry in
// RULE_11 - and immediate nibble into accumulator
// RULE_12 - and memory into accumulator
// RULE_13 - and accumulator into memory
// RULE_14 - call pushes pc plus two, jumps
// RULE_15 - clear carry flag only
// RULE_16 - decimal adjust: add six when needed
// RULE_17 - decrement accumulator, carry kept
// RULE_18 - decrement selected working register zero to four
// RULE_19 - decrement pointed memory, carry kept
// RULE_20 - fetch second byte first, pc plus two
`timescale 1ns/1ns
`default_nettype none
`include "nibble_exec_map.svh"

module nibble_cpu_exec_subset #(
    parameter int RAM_DEPTH = 128
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] rom_data,
    output logic [11:0] rom_addr,
    output logic [3:0] acc,
    output logic carry_flag,
    output logic [3:0] table_high,
    output logic [11:0] return_addr,
    output logic halted,
    output logic bad_opcode,
    output nibble_exec_pkg::sound_ctrl_t sound
);

    localparam int AW = $clog2(RAM_DEPTH);

    if (RAM_DEPTH < 2 || RAM_DEPTH > 256 || (1 << AW) != RAM_DEPTH)
    begin : g_depth_check
        $error("RAM_DEPTH must be a power of two from 2 to 256");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    nibble_exec_pkg::state_t st_reg, st_next;
    logic [11:0] pc_reg, pc_next;
    logic [11:0] rom_addr_reg, rom_addr_next;
    logic [7:0] op_reg, op_next;
    logic [3:0] acc_reg, acc_next;
    logic carry_flag_reg, carry_flag_next;
    logic [4:0][3:0] working_reg, working_next;
    logic [11:0] stack_reg, stack_next;
    logic halt_reg, halt_next;
    logic bad_reg, bad_next;
    nibble_exec_pkg::sound_ctrl_t sound_reg, sound_next;

    logic [3:0] mem [RAM_DEPTH];
    logic mem_we;
    logic [3:0] mem_wd;
    logic [7:0] pointer_pair_low;
    logic [AW-1:0] mem_idx;
    logic [3:0] mem_rd;
    logic [3:0] immediate_nibble;
    logic [2:0] working_reg_sel;

    nibble_exec_pkg::alu_op_t alu_op;
    logic [3:0] alu_a;
    logic [3:0] alu_b;
    logic alu_cin;
    logic [3:0] alu_y;
    logic alu_cout;

    assign pointer_pair_low = {working_reg[1], working_reg[0]};
    assign mem_idx = pointer_pair_low[AW-1:0];
    assign mem_rd = mem[mem_idx];
    assign immediate_nibble = rom_data[3:0];
    assign working_reg_sel = rom_data[3:1];

    ////////////////////////////////////////////////////////////////////////////
    // alu operand selection
    always_comb
    begin
        alu_op = nibble_exec_pkg::ALU_PASS;
        alu_a = acc_reg;
        alu_b = mem_rd;
        alu_cin = carry_flag_reg;
        if (st_reg == nibble_exec_pkg::ST_OP)
        begin
            casez (rom_data)
                `OPC_ADC_MEM: alu_op = nibble_exec_pkg::ALU_ADC; // [RULE_08]
                `OPC_ADD_MEM: alu_op = nibble_exec_pkg::ALU_ADD; // [RULE_10]
                `OPC_AND_ACC_M, `OPC_AND_M_ACC: alu_op = nibble_exec_pkg::ALU_AND; // [RULE_12] [RULE_13]
                `OPC_DEC_ADJ: alu_op = nibble_exec_pkg::ALU_DADJ; // [RULE_16]
                `OPC_DEC_ACC: alu_op = nibble_exec_pkg::ALU_DEC; // [RULE_17]
                `OPC_DEC_MEM:
                begin
                    alu_op = nibble_exec_pkg::ALU_DEC; // [RULE_19]
                    alu_a = mem_rd;
                end
                `OPC_DEC_REG:
                begin
                    alu_op = nibble_exec_pkg::ALU_DEC; // [RULE_18]
                    if (working_reg_sel <= `REG_N_MAX)
                    begin
                        alu_a = working_reg[working_reg_sel];
                    end
                end
                default: alu_op = nibble_exec_pkg::ALU_PASS;
            endcase
        end
        else if (st_reg == nibble_exec_pkg::ST_OPND)
        begin
            alu_b = immediate_nibble;
            if (op_reg == `OPC_ADD_IMM)
            begin
                alu_op = nibble_exec_pkg::ALU_ADD; // [RULE_09]
            end
            else if (op_reg == `OPC_AND_IMM)
            begin
                alu_op = nibble_exec_pkg::ALU_AND; // [RULE_11]
            end
        end
    end

    nibble_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .cin(alu_cin),
        .y(alu_y),
        .cout(alu_cout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and execute
    always_comb
    begin
        st_next = st_reg;
        pc_next = pc_reg;
        rom_addr_next = rom_addr_reg;
        op_next = op_reg;
        acc_next = acc_reg;
        carry_flag_next = carry_flag_reg;
        working_next = working_reg;
        stack_next = stack_reg;
        halt_next = halt_reg;
        bad_next = 1'b0;
        sound_next = sound_reg;
        sound_next.start = 1'b0;
        mem_we = 1'b0;
        mem_wd = alu_y;
        unique case (st_reg)
            nibble_exec_pkg::ST_BOOT:
            begin
                // rom needs one cycle before the first opcode is valid
                st_next = nibble_exec_pkg::ST_OP;
            end
            nibble_exec_pkg::ST_OP:
            begin
                pc_next = pc_reg + `PC_STEP_1;
                rom_addr_next = pc_reg + `PC_STEP_1;
                casez (rom_data)
                    `OPC_ADC_MEM, `OPC_ADD_MEM, `OPC_AND_ACC_M, `OPC_DEC_ADJ, `OPC_DEC_ACC:
                    begin
                        acc_next = alu_y; // [RULE_08] [RULE_10] [RULE_12] [RULE_16] [RULE_17]
                        carry_flag_next = alu_cout;
                    end
                    `OPC_AND_M_ACC, `OPC_DEC_MEM:
                    begin
                        mem_we = 1'b1; // [RULE_13] [RULE_19]
                    end
                    `OPC_DEC_REG:
                    begin
                        if (working_reg_sel <= `REG_N_MAX)
                        begin
                            working_next[working_reg_sel] = alu_y; // [RULE_18]
                        end
                        else
                        begin
                            bad_next = 1'b1;
                        end
                    end
                    `OPC_CLEAR_C:
                    begin
                        carry_flag_next = 1'b0; // [RULE_15]
                    end
                    `OPC_READ_R4A, `OPC_READ_MRA, `OPC_ROM_FETCH_FIXED_PAGE_R4A, `OPC_ROM_FETCH_FIXED_PAGE_MRA:
                    begin
                        // table address low byte is acc then the pointed nibble
                        op_next = rom_data;
                        pc_next = pc_reg;
                        st_next = nibble_exec_pkg::ST_TBL;
                        if (rom_data[0])
                        begin
                            rom_addr_next = {`FIXED_PAGE, acc_reg, mem_rd}; // [RULE_03]
                        end
                        else
                        begin
                            rom_addr_next = {pc_reg[11:8], acc_reg, mem_rd}; // [RULE_01] [RULE_02]
                        end
                    end
                    `OPC_SOUND_A:
                    begin
                        sound_next.channel = acc_reg; // [RULE_05]
                        sound_next.on = 1'b1;
                        sound_next.start = 1'b1;
                    end
                    `OPC_SOUND_ONE, `OPC_SOUND_LOOP:
                    begin
                        sound_next.on = 1'b1; // [RULE_06]
                        sound_next.loop = (rom_data == `OPC_SOUND_LOOP);
                        sound_next.start = 1'b1;
                    end
                    `OPC_SOUND_OFF:
                    begin
                        sound_next.on = 1'b0; // [RULE_06]
                        sound_next.loop = 1'b0;
                    end
                    `OPC_ADD_IMM, `OPC_AND_IMM, `OPC_SOUND_N, `OPC_HALT_1, `OPC_CALL:
                    begin
                        // second byte is fetched before anything executes
                        op_next = rom_data; // [RULE_20]
                        pc_next = pc_reg;
                        st_next = nibble_exec_pkg::ST_OPND;
                    end
                    default:
                    begin
                        // instructions outside this subset are skipped as one byte
                        bad_next = 1'b1;
                    end
                endcase
            end
            nibble_exec_pkg::ST_OPND:
            begin
                pc_next = pc_reg + `PC_STEP_2; // [RULE_20]
                rom_addr_next = pc_reg + `PC_STEP_2;
                st_next = nibble_exec_pkg::ST_OP;
                casez (op_reg)
                    `OPC_ADD_IMM, `OPC_AND_IMM:
                    begin
                        acc_next = alu_y; // [RULE_09] [RULE_11]
                        carry_flag_next = alu_cout;
                    end
                    `OPC_SOUND_N:
                    begin
                        sound_next.channel = immediate_nibble; // [RULE_04]
                        sound_next.on = 1'b1;
                        sound_next.start = 1'b1;
                    end
                    `OPC_HALT_1:
                    begin
                        if (rom_data == `OPC_HALT_2)
                        begin
                            halt_next = 1'b1; // [RULE_07]
                            st_next = nibble_exec_pkg::ST_HALT;
                        end
                        else
                        begin
                            bad_next = 1'b1;
                        end
                    end
                    `OPC_CALL:
                    begin
                        stack_next = pc_reg + `PC_STEP_2; // [RULE_14]
                        pc_next = {op_reg[3:0], rom_data};
                        rom_addr_next = {op_reg[3:0], rom_data};
                    end
                    default: bad_next = 1'b1;
                endcase
            end
            nibble_exec_pkg::ST_TBL:
            begin
                pc_next = pc_reg + `PC_STEP_1;
                rom_addr_next = pc_reg + `PC_STEP_1;
                st_next = nibble_exec_pkg::ST_OP;
                acc_next = rom_data[3:0]; // [RULE_01] [RULE_02]
                if (op_reg[1])
                begin
                    working_next[4] = rom_data[7:4]; // [RULE_01]
                end
                else
                begin
                    mem_we = 1'b1; // [RULE_02]
                    mem_wd = rom_data[7:4];
                end
            end
            nibble_exec_pkg::ST_HALT:
            begin
                // only reset leaves power-down; nothing else moves
                st_next = nibble_exec_pkg::ST_HALT;
            end
            default:
            begin
                st_next = nibble_exec_pkg::ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= nibble_exec_pkg::ST_BOOT;
            pc_reg <= `PC_RESET;
            rom_addr_reg <= `PC_RESET;
            op_reg <= 8'h00;
            acc_reg <= 4'h0;
            carry_flag_reg <= 1'b0;
            working_reg <= '0;
            stack_reg <= `PC_RESET;
            halt_reg <= 1'b0;
            bad_reg <= 1'b0;
            sound_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            pc_reg <= pc_next;
            rom_addr_reg <= rom_addr_next;
            op_reg <= op_next;
            acc_reg <= acc_next;
            carry_flag_reg <= carry_flag_next;
            working_reg <= working_next;
            stack_reg <= stack_next;
            halt_reg <= halt_next;
            bad_reg <= bad_next;
            sound_reg <= sound_next;
        end
    end

    // data memory has no reset, as in the real array
    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
        begin
            mem[mem_idx] <= mem_wd;
        end
    end

    assign rom_addr = rom_addr_reg;
    assign acc = acc_reg;
    assign carry_flag = carry_flag_reg;
    assign table_high = working_reg[4];
    assign return_addr = stack_reg;
    assign halted = halt_reg;
    assign bad_opcode = bad_reg;
    assign sound = sound_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_table_two_cycles: assert property ( // [RULE_01]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_READ_R4A
        |=> st_reg == nibble_exec_pkg::ST_TBL ##1 st_reg == nibble_exec_pkg::ST_OP
            && table_high == $past(rom_data[7:4]) && acc == $past(rom_data[3:0]))
        else $error("table read to high register wrong");
    a_table_to_mem: assert property ( // [RULE_02]
        st_reg == nibble_exec_pkg::ST_TBL && op_reg == `OPC_READ_MRA
        |-> mem_we && mem_wd == rom_data[7:4] && acc_next == rom_data[3:0])
        else $error("table read to memory wrong");
    a_fixed_page: assert property ( // [RULE_03]
        st_reg == nibble_exec_pkg::ST_OP && (rom_data == `OPC_ROM_FETCH_FIXED_PAGE_R4A || rom_data == `OPC_ROM_FETCH_FIXED_PAGE_MRA)
        |=> rom_addr[11:8] == `FIXED_PAGE && st_reg == nibble_exec_pkg::ST_TBL)
        else $error("fixed page read not on page F");
    a_sound_imm: assert property ( // [RULE_04]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_SOUND_N
        ##1 st_reg == nibble_exec_pkg::ST_OPND
        |=> sound.channel == $past(rom_data[3:0]) && sound.on && sound.start)
        else $error("immediate sound channel wrong");
    a_sound_acc: assert property ( // [RULE_05]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_SOUND_A
        |=> sound.channel == $past(acc) && sound.start)
        else $error("accumulator sound channel wrong");
    // a start command right behind it may legally hold the pulse up
    a_sound_pulse: assert property ( // [RULE_05]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_SOUND_A
        ##1 !(rom_data inside {`OPC_SOUND_A, `OPC_SOUND_ONE, `OPC_SOUND_LOOP})
        |=> !sound.start)
        else $error("sound start pulse too long");
    a_sound_off: assert property ( // [RULE_06]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_SOUND_OFF |=> !sound.on && !sound.loop)
        else $error("sound not stopped");
    a_halt_stays: assert property ( // [RULE_07]
        halted |=> halted && $stable(rom_addr) && $stable(acc))
        else $error("halt state not held");
    a_call_target: assert property ( // [RULE_14]
        st_reg == nibble_exec_pkg::ST_OPND && op_reg[7:4] == 4'hF
        |=> rom_addr == {$past(op_reg[3:0]), $past(rom_data)}
            && return_addr == 12'($past(pc_reg) + `PC_STEP_2))
        else $error("call target or return address wrong");
    a_clear_carry: assert property ( // [RULE_15]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_CLEAR_C |=> !carry_flag && $stable(acc))
        else $error("clear carry failed");
    a_dec_adjust: assert property ( // [RULE_16]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_DEC_ADJ && acc > `DEC_ADJ_LIMIT
        |=> carry_flag && acc == 4'($past(acc) + `DEC_ADJ_ADD))
        else $error("decimal adjust wrong");
    a_dec_acc: assert property ( // [RULE_17]
        st_reg == nibble_exec_pkg::ST_OP && rom_data == `OPC_DEC_ACC
        |=> acc == 4'($past(acc) - `NIBBLE_ONE) && $stable(carry_flag))
        else $error("accumulator decrement wrong");
    a_two_byte_pc: assert property ( // [RULE_20]
        st_reg == nibble_exec_pkg::ST_OPND && op_reg[7:4] != 4'hF
        |=> rom_addr == 12'($past(pc_reg) + `PC_STEP_2))
        else $error("two-byte instruction did not advance by two");

endmodule
`default_nettype wire

// File: hdl/nibble_exec_map.svh
// constants for the nibble core execute subset: opcodes, fields, reset values
// assumes one clock; included by bare name from every design file that needs it
`ifndef NIBBLE_EXEC_MAP_SVH
`define NIBBLE_EXEC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// opcodes given by the instruction definitions
`define OPC_ADC_MEM    8'h08
`define OPC_ADD_MEM    8'h09
`define OPC_DEC_MEM    8'h0D
`define OPC_AND_ACC_M  8'h1A
`define OPC_AND_M_ACC  8'h1D
`define OPC_DEC_REG    8'b0001_???1
`define OPC_CLEAR_C    8'h2A
`define OPC_DEC_ADJ    8'h36
`define OPC_DEC_ACC    8'h3F
`define OPC_ADD_IMM    8'h40
`define OPC_AND_IMM    8'h42
`define OPC_CALL       8'hF?

////////////////////////////////////////////////////////////////////////////////
// opcodes with no printed code: table reads, sound, power-down
`define OPC_READ_R4A   8'h4E
`define OPC_READ_MRA   8'h4C
`define OPC_ROM_FETCH_FIXED_PAGE_R4A  8'h4F
`define OPC_ROM_FETCH_FIXED_PAGE_MRA  8'h4D
`define OPC_SOUND_N    8'h45
`define OPC_SOUND_A    8'h4B
`define OPC_SOUND_ONE  8'h49
`define OPC_SOUND_LOOP 8'h4A
`define OPC_SOUND_OFF  8'h48
`define OPC_HALT_1     8'h37
`define OPC_HALT_2     8'h3E

////////////////////////////////////////////////////////////////////////////////
// fields, limits and reset values
`define FIXED_PAGE     4'hF
`define DEC_ADJ_LIMIT  4'h9
`define DEC_ADJ_ADD    4'h6
`define REG_N_MAX      3'h4
`define PC_RESET       12'h000
`define PC_STEP_1      12'h001
`define PC_STEP_2      12'h002
`define NIBBLE_ONE     4'h1

`endif

// File: hdl/nibble_exec_pkg.sv
// types shared by the execute subset and its nibble alu
// assumes the constants header holds all numeric values
package nibble_exec_pkg;

    typedef enum logic [4:0]
    {
        ST_BOOT = 5'h01,
        ST_OP   = 5'h02,
        ST_OPND = 5'h04,
        ST_TBL  = 5'h08,
        ST_HALT = 5'h10
    } state_t;

    typedef enum logic [2:0]
    {
        ALU_PASS = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_ADC  = 3'h2,
        ALU_AND  = 3'h3,
        ALU_DEC  = 3'h4,
        ALU_DADJ = 3'h5
    } alu_op_t;

    typedef struct packed
    {
        logic [3:0] channel;
        logic on;
        logic loop;
        logic start;
    } sound_ctrl_t;

endpackage

// File: testbench/testbench.sv
// self-checking bench for the nibble execute subset: table, alu, sound, call, halt
// assumes the bench plays the one-cycle program rom by presenting each byte at the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "nibble_exec_map.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module testbench;

////////////////////////////////////////////////////////////////////////////////
typedef struct packed
{
    logic [7:0] b0;
    logic [7:0] b1;
    logic two;
    logic [11:0] mid;
    logic [11:0] pc;
    logic [3:0] a;
    logic [3:0] th;
    logic c;
    logic [5:0] snd;
} row_t;

logic ref_clk;
logic rst;
logic [7:0] rom_data;
logic [11:0] rom_addr;
logic [3:0] acc;
logic carry_flag;
logic [3:0] table_high;
logic [11:0] return_addr;
logic halted;
logic bad_opcode;
nibble_exec_pkg::sound_ctrl_t sound;
int n_mismatch = 0;
int compares = 0;
logic [11:0] held;

// mid 12'hFFF skips the mid check: the first table address holds memory not yet written
row_t rows [29] = '{
    '{8'h4D, 8'h73, 1'h1, 12'hFFF, 12'h001, 4'h3, 4'h0, 1'h0, 6'h00},
    '{8'h4E, 8'h92, 1'h1, 12'h037, 12'h002, 4'h2, 4'h9, 1'h0, 6'h00},
    '{8'h4F, 8'hC5, 1'h1, 12'hF27, 12'h003, 4'h5, 4'hC, 1'h0, 6'h00},
    '{8'h4C, 8'h48, 1'h1, 12'h057, 12'h004, 4'h8, 4'hC, 1'h0, 6'h00},
    '{8'h09, 8'h00, 1'h0, 12'h000, 12'h005, 4'hC, 4'hC, 1'h0, 6'h00},
    '{8'h08, 8'h00, 1'h0, 12'h000, 12'h006, 4'h0, 4'hC, 1'h1, 6'h00},
    '{8'h08, 8'h00, 1'h0, 12'h000, 12'h007, 4'h5, 4'hC, 1'h0, 6'h00},
    '{8'h40, 8'h0D, 1'h1, 12'h008, 12'h009, 4'h2, 4'hC, 1'h1, 6'h00},
    '{8'h36, 8'h00, 1'h0, 12'h000, 12'h00A, 4'h8, 4'hC, 1'h1, 6'h00},
    '{8'h2A, 8'h00, 1'h0, 12'h000, 12'h00B, 4'h8, 4'hC, 1'h0, 6'h00},
    '{8'h36, 8'h00, 1'h0, 12'h000, 12'h00C, 4'h8, 4'hC, 1'h0, 6'h00},
    '{8'h40, 8'h03, 1'h1, 12'h00D, 12'h00E, 4'hB, 4'hC, 1'h0, 6'h00},
    '{8'h36, 8'h00, 1'h0, 12'h000, 12'h00F, 4'h1, 4'hC, 1'h1, 6'h00},
    '{8'h3F, 8'h00, 1'h0, 12'h000, 12'h010, 4'h0, 4'hC, 1'h1, 6'h00},
    '{8'h3F, 8'h00, 1'h0, 12'h000, 12'h011, 4'hF, 4'hC, 1'h1, 6'h00},
    '{8'h42, 8'h06, 1'h1, 12'h012, 12'h013, 4'h6, 4'hC, 1'h1, 6'h00},
    '{8'h1A, 8'h00, 1'h0, 12'h000, 12'h014, 4'h4, 4'hC, 1'h1, 6'h00},
    '{8'h3F, 8'h00, 1'h0, 12'h000, 12'h015, 4'h3, 4'hC, 1'h1, 6'h00},
    '{8'h1D, 8'h00, 1'h0, 12'h000, 12'h016, 4'h3, 4'hC, 1'h1, 6'h00},
    '{8'h09, 8'h00, 1'h0, 12'h000, 12'h017, 4'h3, 4'hC, 1'h0, 6'h00},
    '{8'h0D, 8'h00, 1'h0, 12'h000, 12'h018, 4'h3, 4'hC, 1'h0, 6'h00},
    '{8'h09, 8'h00, 1'h0, 12'h000, 12'h019, 4'h2, 4'hC, 1'h1, 6'h00},
    '{8'h19, 8'h00, 1'h0, 12'h000, 12'h01A, 4'h2, 4'hB, 1'h1, 6'h00},
    '{8'h45, 8'h03, 1'h1, 12'h01B, 12'h01C, 4'h2, 4'hB, 1'h1, 6'h0E},
    '{8'h4A, 8'h00, 1'h0, 12'h000, 12'h01D, 4'h2, 4'hB, 1'h1, 6'h0F},
    '{8'h4B, 8'h00, 1'h0, 12'h000, 12'h01E, 4'h2, 4'hB, 1'h1, 6'h0B},
    '{8'h48, 8'h00, 1'h0, 12'h000, 12'h01F, 4'h2, 4'hB, 1'h1, 6'h08},
    '{8'h49, 8'h00, 1'h0, 12'h000, 12'h020, 4'h2, 4'hB, 1'h1, 6'h0A},
    '{8'hF1, 8'h23, 1'h1, 12'h021, 12'h123, 4'h2, 4'hB, 1'h1, 6'h0A}
};

nibble_cpu_exec_subset uut (
    .ref_clk(ref_clk),
    .rst(rst),
    .rom_data(rom_data),
    .rom_addr(rom_addr),
    .acc(acc),
    .carry_flag(carry_flag),
    .table_high(table_high),
    .return_addr(return_addr),
    .halted(halted),
    .bad_opcode(bad_opcode),
    .sound(sound)
);

////////////////////////////////////////////////////////////////////////////////
initial
begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
end

// called at a falling edge, returns at the next one with the byte taken
task automatic feed(input logic [7:0] b);
    rom_data = b;
    @(posedge ref_clk);
    @(negedge ref_clk);
endtask

task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask

// whole run is under 200 cycles; ten times that means a hang
initial
begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
end

////////////////////////////////////////////////////////////////////////////////
initial
begin
    rst = 1'h1;
    rom_data = 8'h00;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    foreach (rows[i])
    begin
        feed(rows[i].b0);
        if (rows[i].two)
        begin
            if (rows[i].mid !== 12'hFFF)
                `CHK(rom_addr, rows[i].mid)
            feed(rows[i].b1);
        end
        `CHK(rom_addr, rows[i].pc)
        `CHK(acc, rows[i].a)
        `CHK(carry_flag, rows[i].c)
        `CHK(table_high, rows[i].th)
        `CHK(sound[6:1], rows[i].snd)
        $display("row %0d done", i);
    end
    `CHK(return_addr, 12'h022)
    // sound from accumulator, then an out-of-range register decrement
    feed(8'h4B);
    `CHK(sound.start, 1'h1)
    feed(8'h1B);
    `CHK(sound.start, 1'h0)
    `CHK(bad_opcode, 1'h1)
    `CHK(rom_addr, 12'h125)
    // a wrong second byte is refused, and the 8'h00 after it is flagged again as outside the subset
    feed(`OPC_HALT_1);
    `CHK(bad_opcode, 1'h0)
    feed(8'h00);
    `CHK({halted, bad_opcode}, 2'h1)
    `CHK(rom_addr, 12'h127)
    feed(8'h00);
    `CHK({bad_opcode, rom_addr}, 13'h1128)
    $display("sound start and bad register done");
    // power-down: nothing after it may execute
    feed(`OPC_HALT_1);
    feed(`OPC_HALT_2);
    `CHK(halted, 1'h1)
    held = rom_addr;
    feed(8'h3F);
    feed(8'h3F);
    `CHK(rom_addr, held)
    `CHK(acc, 4'h2)
    `CHK(halted, 1'h1)
    $display("halt done");
    // reset in mid-run is the only way out of halt
    rst = 1'h1;
    @(negedge ref_clk);
    `CHK({acc, carry_flag, table_high, halted}, 10'h000)
    `CHK({rom_addr, return_addr, sound}, 31'h00000000)
    rst = 1'h0;
    // first edge after release is the rom latency slot and must not execute
    @(negedge ref_clk);
    `CHK({acc, rom_addr}, 16'h0000)
    feed(8'h3F);
    `CHK({acc, rom_addr}, 16'hF001)
    $display("reset done");
    stop_test();
end

endmodule
`default_nettype wire
